// [ubu_pkg.sv]
// Shared constants for the bridged serial port function
// Assumes a single 125 MHz clock domain
package ubu_pkg;
	// ----------------------------------------------------------------
	// Register map (plain register port, word addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_LINE_CFG   = 4'h0;
	localparam logic [3:0] ADDR_BAUD_DIV   = 4'h1;
	localparam logic [3:0] ADDR_FLOW_CTRL  = 4'h2;
	localparam logic [3:0] ADDR_PIN_MODE   = 4'h3;
	localparam logic [3:0] ADDR_XON_CHAR   = 4'h4;
	localparam logic [3:0] ADDR_XOFF_CHAR  = 4'h5;
	localparam logic [3:0] ADDR_RX_CTRL    = 4'h6;
	localparam logic [3:0] ADDR_ERR_STATUS = 4'h7;
	localparam logic [3:0] ADDR_LINE_RATE  = 4'h8;
	localparam logic [3:0] ADDR_STATUS     = 4'h9;
	// ----------------------------------------------------------------
	// Line configuration fields
	// ----------------------------------------------------------------
	localparam int CFG_BITS_LO  = 0;
	localparam int CFG_PAR_EN   = 2;
	localparam int CFG_PAR_ODD  = 3;
	localparam int CFG_STOP2    = 4;
	localparam int CFG_TX_WIDE  = 5;
	localparam int CFG_RX_WIDE  = 6;
	localparam logic [1:0] BITS_7 = 2'h0;
	localparam logic [1:0] BITS_8 = 2'h1;
	localparam logic [1:0] BITS_9 = 2'h2;
	localparam logic [6:0] LINE_CFG_RST = 7'h01;
	// ----------------------------------------------------------------
	// Flow and pin modes
	// ----------------------------------------------------------------
	localparam logic [2:0] FLOW_OFF = 3'h0;
	localparam logic [2:0] FLOW_HW  = 3'h1;
	localparam logic [2:0] FLOW_SW  = 3'h2;
	localparam logic [2:0] PIN_RTS  = 3'h1;
	localparam logic [2:0] PIN_DTR  = 3'h2;
	localparam logic [2:0] PIN_RST  = 3'h0;
	localparam logic [7:0] XON_RST  = 8'h11;
	localparam logic [7:0] XOFF_RST = 8'h13;
	// ----------------------------------------------------------------
	// Rates and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 125000000;
	localparam int RST_BAUD      = 9600;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (RST_BAUD * 16));
	localparam logic [31:0] LOW_LAT_BAUD = 32'd46921;
	localparam int IDLE_CHARS    = 3;
	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	localparam int QDEPTH   = 1024;
	localparam int QAW      = 10;
	localparam logic [QAW:0] PKT_HS = 11'd512;
	localparam logic [QAW:0] PKT_FS = 11'd64;
	localparam logic [QAW:0] RTS_OFF_LVL = 11'd960;
	localparam logic [QAW:0] RTS_ON_LVL  = 11'd768;
endpackage : ubu_pkg

// [ubu_fifo.sv]
// Byte queue with valid/ready on both sides
// Assumes one clock, one reset
`timescale 1ns/1ps
`default_nettype none
module ubu_fifo
	import ubu_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         wr_valid,
	output logic              wr_ready,
	input  wire logic [7:0]   wr_data,
	output logic              rd_valid,
	input  wire logic         rd_ready,
	output logic [7:0]        rd_data,
	output logic [QAW:0]      level
);
	logic [7:0]     mem [QDEPTH];
	logic [QAW:0]   wp_ff;
	logic [QAW:0]   rp_ff;
	logic           do_wr;
	logic           do_rd;

	assign level    = wp_ff - rp_ff;
	assign wr_ready = (level != 11'(QDEPTH));
	assign rd_valid = (level != 11'h000);
	assign rd_data  = mem[rp_ff[QAW-1:0]];
	assign do_wr    = wr_valid && wr_ready;
	assign do_rd    = rd_valid && rd_ready;

	always_ff @(posedge mclk)
	begin
		if (do_wr)
			mem[wp_ff[QAW-1:0]] <= wr_data;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
		end
		else
		begin
			if (do_wr)
				wp_ff <= wp_ff + 11'h001;
			if (do_rd)
				rp_ff <= rp_ff + 11'h001;
		end
	end
endmodule : ubu_fifo
`default_nettype wire

// [ubu_uart.sv]
// Serial port function of a USB bridge: queues, shifters, flow control
// Assumes USB side delivers CRC-checked bulk-out bytes and polls bulk-in
//
// Functional notes
// - Reset gives 9600 bit/s, 8 bits, no parity, one stop, no flow control.
// - Bulk-out bytes enter transmit queue only after packet CRC is good.
// - Transmit shifter loads next queued byte when idle or finished.
// - Frame is start, data LSB first, optional parity, stop bits.
// - Formats 7 or 8 bits with optional parity, or 9 bits without.
// - Nine-bit send without transmit wide mode sends ninth bit zero.
// - Transmit wide nine-bit takes two bytes; second byte bit 0 is bit 8.
// - Received characters go to a 1024-byte queue drained by bulk-in.
// - Normal 7/8-bit receive queues data only, drops status.
// - Normal 9-bit receive queues low eight bits, drops ninth and status.
// - Wide 7/8-bit receive queues data then error and break byte.
// - Wide 9-bit second byte: bit 0 ninth bit, framing, overrun, break.
// - Error status flags are sticky until read.
// - Bulk-in answers with full 512 or 64 byte packets normally.
// - Short packet sent after more than three idle character times.
// - Low-latency bit sends queued data immediately.
// - Line rate below 46921 via line coding sets low latency.
// - RTS/CTS handshake only with pin mode 001 and flow mode 001.
// - Handshake output drops before receive queue overruns, returns later.
// - Transmitter pauses while remote clear-to-send is deasserted.
// - Pin mode 010 moves the same handshake onto DTR/DSR.
// - Flow mode 010 matches XOFF to halt, XON to resume transmission.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module ubu_uart
	import ubu_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [3:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [31:0]       reg_rdata,
	input  wire logic [7:0]   out_data,
	input  wire logic         out_valid,
	input  wire logic         out_pkt_end,
	input  wire logic         out_crc_ok,
	output logic              out_ready,
	input  wire logic         hi_speed,
	input  wire logic         in_req,
	output logic              in_ack,
	output logic              in_nak,
	output logic [10:0]       in_len,
	input  wire logic         in_pop,
	output logic [7:0]        in_data,
	output logic              txd,
	input  wire logic         rxd,
	output logic              rts_n,
	input  wire logic         cts_n,
	output logic              dtr_n,
	input  wire logic         dsr_n
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [6:0]   line_cfg_ff;
	logic [15:0]  baud_div_ff;
	logic [2:0]   flow_ff;
	logic [2:0]   pin_ff;
	logic [7:0]   xon_ff;
	logic [7:0]   xoff_ff;
	logic         low_lat_ff;
	logic [3:0]   err_ff;
	logic [31:0]  rate_ff;
	logic [2:0]   rx_s1_ff, rx_s2_ff;
	logic         rxs_ff, cts_s_ff, dsr_s_ff;
	logic [1:0]   bits;
	logic [3:0]   nbits;
	logic         par_en;
	logic         hs_on;
	logic         remote_ok;
	logic         xoff_ff_halt;

	assign bits   = line_cfg_ff[CFG_BITS_LO +: 2];
	assign nbits  = (bits == BITS_7) ? 4'h7 : (bits == BITS_8) ? 4'h8 : 4'h9;
	assign par_en = line_cfg_ff[CFG_PAR_EN] && (bits != BITS_9);
	assign hs_on  = (flow_ff == FLOW_HW) && ((pin_ff == PIN_RTS) || (pin_ff == PIN_DTR));
	assign remote_ok = !hs_on || ((pin_ff == PIN_DTR) ? !dsr_s_ff : !cts_s_ff);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_s1_ff <= 3'h7;
			rx_s2_ff <= 3'h7;
		end
		else
		begin
			rx_s1_ff <= {rxd, cts_n, dsr_n};
			rx_s2_ff <= rx_s1_ff;
		end
	end
	assign rxs_ff   = rx_s2_ff[2];
	assign cts_s_ff = rx_s2_ff[1];
	assign dsr_s_ff = rx_s2_ff[0];

	// ----------------------------------------------------------------
	// Queues
	// ----------------------------------------------------------------
	logic         txq_rv, txq_rr, txq_wr;
	logic [7:0]   txq_rd;
	logic         rxq_wv, rxq_wr;
	logic [7:0]   rxq_wd;
	logic         rxq_rv;
	logic [QAW:0] rxq_lvl;
	logic [7:0]   stage_ff [8];
	logic [3:0]   stg_n_ff;
	logic         drain_ff;
	logic [3:0]   drain_i_ff;

	// packet staged until CRC checked, then drained to queue
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stg_n_ff   <= 4'h0;
			drain_ff   <= 1'b0;
			drain_i_ff <= 4'h0;
		end
		else if (drain_ff)
		begin
			if (txq_wr)
			begin
				drain_i_ff <= drain_i_ff + 4'h1;
				if (drain_i_ff + 4'h1 == stg_n_ff)
				begin
					drain_ff <= 1'b0;
					stg_n_ff <= 4'h0;
				end
			end
		end
		else if (out_valid && stg_n_ff != 4'h8)
		begin
			stage_ff[stg_n_ff[2:0]] <= out_data;
			if (out_pkt_end)
			begin
				drain_ff   <= out_crc_ok;
				drain_i_ff <= 4'h0;
				stg_n_ff   <= out_crc_ok ? stg_n_ff + 4'h1 : 4'h0;
			end
			else
				stg_n_ff <= stg_n_ff + 4'h1;
		end
	end
	assign out_ready = !drain_ff && (stg_n_ff != 4'h8);

	ubu_fifo u_txq (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.wr_valid (drain_ff),
		.wr_ready (txq_wr),
		.wr_data  (stage_ff[drain_i_ff[2:0]]),
		.rd_valid (txq_rv),
		.rd_ready (txq_rr),
		.rd_data  (txq_rd),
		.level    ()
	);

	ubu_fifo u_rxq (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.wr_valid (rxq_wv),
		.wr_ready (rxq_wr),
		.wr_data  (rxq_wd),
		.rd_valid (rxq_rv),
		.rd_ready (in_pop),
		.rd_data  (in_data),
		.level    (rxq_lvl)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {TX_IDLE = 4'h1, TX_HI = 4'h2, TX_SHIFT = 4'h4, TX_WAIT = 4'h8} ubu_tx_t;
	ubu_tx_t      tx_st_ff;
	logic [11:0]  tx_sh_ff;
	logic [3:0]   tx_cnt_ff;
	logic [3:0]   tx_tick_ff;
	logic [15:0]  tx_div_ff;
	logic [7:0]   tx_lo_ff;
	logic         tx_go;
	logic [8:0]   tx_word;

	assign tx_go  = remote_ok && !xoff_ff_halt;
	assign txq_rr = (tx_st_ff == TX_IDLE && tx_go) ||
		(tx_st_ff == TX_WAIT && bits == BITS_9 && line_cfg_ff[CFG_TX_WIDE]);
	assign tx_word = {(bits == BITS_9) && line_cfg_ff[CFG_TX_WIDE] && txq_rd[0], tx_lo_ff};

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_st_ff   <= TX_IDLE;
			tx_sh_ff   <= 12'hFFF;
			tx_cnt_ff  <= 4'h0;
			tx_tick_ff <= 4'h0;
			tx_div_ff  <= 16'h0000;
			tx_lo_ff   <= 8'h00;
			txd        <= 1'b1;
		end
		else
		begin
			case (tx_st_ff)
				TX_IDLE:
				begin
					txd <= 1'b1;
					if (txq_rv && tx_go)
					begin
						tx_lo_ff <= txq_rd;
						// wide nine-bit needs a second byte
						if ((bits == BITS_9) && line_cfg_ff[CFG_TX_WIDE])
							tx_st_ff <= TX_HI;
						else
							tx_st_ff <= TX_WAIT;
					end
				end
				TX_HI:
				begin
					if (txq_rv)
						tx_st_ff <= TX_WAIT;
				end
				TX_WAIT:
				begin
					// start, data LSB first, parity, stop
					tx_sh_ff <= {2'b11, tx_word, 1'b0};
					if (nbits == 4'h7)
						tx_sh_ff[9:8] <= {1'b1, par_en ? (^tx_word[6:0] ^ line_cfg_ff[CFG_PAR_ODD]) : 1'b1};
					else if (nbits == 4'h8)
						tx_sh_ff[9] <= par_en ? (^tx_word[7:0] ^ line_cfg_ff[CFG_PAR_ODD]) : 1'b1;
					tx_cnt_ff  <= nbits + 4'(par_en) + 4'(line_cfg_ff[CFG_STOP2]) + 4'h2;
					tx_tick_ff <= 4'h0;
					tx_div_ff  <= 16'h0000;
					tx_st_ff   <= TX_SHIFT;
				end
				TX_SHIFT:
				begin
					txd <= tx_sh_ff[0];
					if (tx_div_ff + 16'h0001 >= baud_div_ff)
					begin
						tx_div_ff  <= 16'h0000;
						tx_tick_ff <= tx_tick_ff + 4'h1;
						if (tx_tick_ff == 4'hF)
						begin
							tx_sh_ff  <= {1'b1, tx_sh_ff[11:1]};
							tx_cnt_ff <= tx_cnt_ff - 4'h1;
							if (tx_cnt_ff == 4'h1)
								tx_st_ff <= TX_IDLE;
						end
					end
					else
						tx_div_ff <= tx_div_ff + 16'h0001;
				end
				default:
					tx_st_ff <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	logic         rx_busy_ff;
	logic [15:0]  rx_div_ff;
	logic [3:0]   rx_tick_ff;
	logic [3:0]   rx_idx_ff;
	logic [10:0]  rx_sh_ff;
	logic         rx_done_ff;
	logic [8:0]   rx_char_ff;
	logic [3:0]   rx_stat_ff;
	logic         rx_second_ff;
	logic [3:0]   rx_last;
	logic         rx_par_bit;
	logic         rx_pe, rx_fe, rx_brk, rx_oe;

	assign rx_last = nbits + 4'(par_en);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_busy_ff <= 1'b0;
			rx_div_ff  <= 16'h0000;
			rx_tick_ff <= 4'h0;
			rx_idx_ff  <= 4'h0;
			rx_sh_ff   <= 11'h000;
			rx_done_ff <= 1'b0;
		end
		else
		begin
			rx_done_ff <= 1'b0;
			if (!rx_busy_ff)
			begin
				rx_div_ff  <= 16'h0000;
				rx_tick_ff <= 4'h0;
				rx_idx_ff  <= 4'h0;
				rx_busy_ff <= !rxs_ff;
			end
			else if (rx_div_ff + 16'h0001 >= baud_div_ff)
			begin
				rx_div_ff  <= 16'h0000;
				rx_tick_ff <= rx_tick_ff + 4'h1;
				if (rx_tick_ff == 4'h7)
				begin
					rx_sh_ff[rx_idx_ff] <= rxs_ff;
					rx_idx_ff <= rx_idx_ff + 4'h1;
					if (rx_idx_ff == 4'h0 && rxs_ff)
						rx_busy_ff <= 1'b0;
					else if (rx_idx_ff == rx_last + 4'h1)
					begin
						rx_busy_ff <= 1'b0;
						rx_done_ff <= 1'b1;
					end
				end
			end
			else
				rx_div_ff <= rx_div_ff + 16'h0001;
		end
	end

	assign rx_par_bit = rx_sh_ff[rx_last];
	assign rx_pe  = par_en && ((^rx_sh_ff[8:1] & (nbits == 4'h8)) ^ (^rx_sh_ff[7:1] & (nbits == 4'h7))
		^ line_cfg_ff[CFG_PAR_ODD] ^ rx_par_bit);
	assign rx_fe  = !rx_sh_ff[rx_last + 4'h1];
	assign rx_brk = rx_fe && (rx_sh_ff[9:0] == 10'h000);
	assign rx_oe  = !rxq_wr;

	// queue data, and status byte in wide mode
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_char_ff   <= 9'h000;
			rx_stat_ff   <= 4'h0;
			rx_second_ff <= 1'b0;
		end
		else if (rx_done_ff)
		begin
			rx_char_ff   <= {bits == BITS_9 && rx_sh_ff[9], (nbits == 4'h7) ? {1'b0, rx_sh_ff[7:1]} : rx_sh_ff[8:1]};
			rx_stat_ff   <= {rx_brk, rx_oe, rx_fe, (bits != BITS_9) && rx_pe};
			rx_second_ff <= line_cfg_ff[CFG_RX_WIDE];
		end
		else if (rx_second_ff && !rx_first_ff && rxq_wr)
			rx_second_ff <= 1'b0;
	end

	logic         rx_first_ff;
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			rx_first_ff <= 1'b0;
		else
			rx_first_ff <= rx_done_ff;
	end
	assign rxq_wv = rx_first_ff || (rx_second_ff && !rx_first_ff);
	assign rxq_wd = rx_first_ff ? rx_char_ff[7:0] : {3'h0, rx_stat_ff, rx_char_ff[8]};

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			xoff_ff_halt <= 1'b0;
		else if (flow_ff != FLOW_SW)
			xoff_ff_halt <= 1'b0;
		else if (rx_first_ff && rx_char_ff[7:0] == xoff_ff)
			xoff_ff_halt <= 1'b1;
		else if (rx_first_ff && rx_char_ff[7:0] == xon_ff)
			xoff_ff_halt <= 1'b0;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end
		else
		begin
			rts_n <= !(hs_on && pin_ff == PIN_RTS && (rts_n ? rxq_lvl < RTS_ON_LVL : rxq_lvl < RTS_OFF_LVL));
			dtr_n <= !(hs_on && pin_ff == PIN_DTR && (dtr_n ? rxq_lvl < RTS_ON_LVL : rxq_lvl < RTS_OFF_LVL));
		end
	end

	// ----------------------------------------------------------------
	// Bulk-in pacing
	// ----------------------------------------------------------------
	logic [31:0]  idle_ff;
	logic [31:0]  idle_lim;
	logic [QAW:0] pkt;
	assign idle_lim = 32'(baud_div_ff) * 32'd16 * 32'(rx_last + 4'h2) * 32'(IDLE_CHARS);
	assign pkt      = hi_speed ? PKT_HS : PKT_FS;

	// idle timer restarts on every character
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			idle_ff <= 32'h00000000;
		else if (rx_done_ff)
			idle_ff <= 32'h00000000;
		else if (idle_ff <= idle_lim)
			idle_ff <= idle_ff + 32'h00000001;
	end

	// ack full packet, or short one after idle or low latency
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			in_ack <= 1'b0;
			in_nak <= 1'b0;
			in_len <= 11'h000;
		end
		else
		begin
			in_ack <= in_req && (rxq_lvl >= pkt || (rxq_rv && (low_lat_ff || idle_ff > idle_lim)));
			in_nak <= in_req && !(rxq_lvl >= pkt || (rxq_rv && (low_lat_ff || idle_ff > idle_lim)));
			in_len <= (rxq_lvl >= pkt) ? pkt : rxq_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// reset values
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			line_cfg_ff <= LINE_CFG_RST;
			baud_div_ff <= BAUD_DIV_RST;
			flow_ff     <= FLOW_OFF;
			pin_ff      <= PIN_RST;
			xon_ff      <= XON_RST;
			xoff_ff     <= XOFF_RST;
			low_lat_ff  <= 1'b0;
			rate_ff     <= 32'(RST_BAUD);
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ADDR_LINE_CFG:  line_cfg_ff <= reg_wdata[6:0];
				ADDR_BAUD_DIV:  baud_div_ff <= reg_wdata[15:0];
				ADDR_FLOW_CTRL: flow_ff     <= reg_wdata[2:0];
				ADDR_PIN_MODE:  pin_ff      <= reg_wdata[2:0];
				ADDR_XON_CHAR:  xon_ff      <= reg_wdata[7:0];
				ADDR_XOFF_CHAR: xoff_ff     <= reg_wdata[7:0];
				ADDR_RX_CTRL:   low_lat_ff  <= reg_wdata[0];
				ADDR_LINE_RATE:
				begin
					rate_ff <= reg_wdata;
					// slow line coding forces low latency
					if (reg_wdata < LOW_LAT_BAUD)
						low_lat_ff <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// sticky errors, set wins over read clear
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			err_ff <= 4'h0;
		else
			err_ff <= ((reg_rd && reg_addr == ADDR_ERR_STATUS) ? 4'h0 : err_ff)
				| (rx_done_ff ? {rx_brk, rx_oe, rx_fe, rx_pe} : 4'h0);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			case (reg_addr)
				ADDR_LINE_CFG:   reg_rdata <= {25'h0, line_cfg_ff};
				ADDR_BAUD_DIV:   reg_rdata <= {16'h0, baud_div_ff};
				ADDR_FLOW_CTRL:  reg_rdata <= {29'h0, flow_ff};
				ADDR_PIN_MODE:   reg_rdata <= {29'h0, pin_ff};
				ADDR_XON_CHAR:   reg_rdata <= {24'h0, xon_ff};
				ADDR_XOFF_CHAR:  reg_rdata <= {24'h0, xoff_ff};
				ADDR_RX_CTRL:    reg_rdata <= {31'h0, low_lat_ff};
				ADDR_ERR_STATUS: reg_rdata <= {28'h0, err_ff};
				ADDR_LINE_RATE:  reg_rdata <= rate_ff;
				ADDR_STATUS:     reg_rdata <= {16'h0, xoff_ff_halt, remote_ok, 3'h0, rxq_lvl};
				default:         reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end
endmodule : ubu_uart
`default_nettype wire

// [ubu_checker.sv]
// Port assertions for the bridged serial port function
// Assumes binding to ubu_uart, one clock, async high reset
`timescale 1ns/1ps
`default_nettype none
module ubu_checker
	import ubu_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        hi_speed,
	input wire logic        in_req,
	input wire logic        in_ack,
	input wire logic        in_nak,
	input wire logic [10:0] in_len,
	input wire logic        txd,
	input wire logic        rts_n,
	input wire logic        dtr_n
);
	logic [2:0] flow_ff;
	logic [2:0] pin_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flow_ff <= FLOW_OFF;
			pin_ff <= PIN_RST;
		end
		else if (reg_wr && reg_addr == ADDR_FLOW_CTRL)
			flow_ff <= reg_wdata[2:0];
		else if (reg_wr && reg_addr == ADDR_PIN_MODE)
			pin_ff <= reg_wdata[2:0];
	end
	property p_ans_one;
		in_req |=> (in_ack ^ in_nak);
	endproperty
	a_ans_one: assert property (p_ans_one) else $error("bulk-in request not answered once");
	property p_ans_cause;
		(in_ack || in_nak) |-> $past(in_req);
	endproperty
	a_ans_cause: assert property (p_ans_cause) else $error("bulk-in answer without request");
	property p_ack_len;
		in_ack |-> in_len != 11'h000;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("acknowledge with no data");
	property p_ack_max;
		in_ack |-> in_len <= (hi_speed ? PKT_HS : PKT_FS);
	endproperty
	a_ack_max: assert property (p_ack_max) else $error("bulk-in longer than a packet");
	property p_start;
		$fell(txd) |=> !txd [*7];
	endproperty
	a_start: assert property (p_start) else $error("start bit too short");
	property p_rts_off;
		!(flow_ff == FLOW_HW && pin_ff == PIN_RTS) [*3] |-> rts_n;
	endproperty
	a_rts_off: assert property (p_rts_off) else $error("rts asserted without handshake");
	property p_dtr_off;
		!(flow_ff == FLOW_HW && pin_ff == PIN_DTR) [*3] |-> dtr_n;
	endproperty
	a_dtr_off: assert property (p_dtr_off) else $error("dtr asserted without handshake");
	property p_flow_echo;
		$past(reg_rd) && $past(reg_addr) == ADDR_FLOW_CTRL |-> reg_rdata[2:0] == flow_ff;
	endproperty
	a_flow_echo: assert property (p_flow_echo) else $error("flow mode readback wrong");
endmodule : ubu_checker
`default_nettype wire

// [ubu_remote.sv]
// Remote serial end: sends frames on rxd, decodes txd
// Assumes bit period of BIT clocks and nb bits after start
`timescale 1ns/1ps
`default_nettype none
module ubu_remote #(
	parameter int BIT = 32
) (
	input  wire logic       mclk,
	input  wire logic       txd,
	output logic            rxd,
	output logic            cts_n,
	output logic            dsr_n,
	input  wire logic       hold,
	input  wire logic [3:0] nb,
	output logic            got_stb,
	output logic [9:0]      got
);
	logic [9:0] v;
	int         j;
	initial
	begin
		rxd = 1'b1;
		got_stb = 1'b0;
		got = '0;
	end
	assign cts_n = hold;
	assign dsr_n = hold;
	task automatic send(input logic [9:0] f);
		int i;
		@(posedge mclk);
		rxd <= 1'b0;
		repeat (BIT) @(posedge mclk);
		for (i = 0; i < nb; i++)
		begin
			rxd <= f[i];
			repeat (BIT) @(posedge mclk);
		end
		rxd <= 1'b1;
		repeat (BIT) @(posedge mclk);
	endtask : send
	always
	begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge mclk);
		v = '0;
		for (j = 0; j < nb; j++)
		begin
			repeat (BIT) @(posedge mclk);
			v[j] = txd;
		end
		repeat (BIT) @(posedge mclk);
		got <= v;
		got_stb <= 1'b1;
		@(posedge mclk);
		got_stb <= 1'b0;
	end
endmodule : ubu_remote
`default_nettype wire

// [tb.sv]
// Self-checking bench for ubu_uart
// Assumes ubu_remote on the serial side, bit time of 32 clocks
`timescale 1ns/1ps
`default_nettype none
module tb
	import ubu_pkg::*;
;
	localparam int BIT = 32;
	logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, hold = 0, hs = 0;
	logic out_valid = 0, out_pkt_end = 0, out_crc_ok = 0, in_req = 0, in_pop = 0;
	logic out_ready, in_ack, in_nak, txd, rxd, rts_n, cts_n, dtr_n, dsr_n, got_stb;
	logic [3:0] reg_addr = 0, nb = 8;
	logic [31:0] reg_wdata = 0, reg_rdata;
	logic [7:0] out_data = 0, in_data, pb[8];
	logic [10:0] in_len;
	logic [9:0] got;
	logic [8:0] d;
	logic [6:0] c;
	logic [6:0] fmt[5] = '{7'h04, 7'h4D, 7'h02, 7'h22, 7'h42};
	logic [9:0] exp_tx[$];
	logic [31:0] exp_rd[$];
	logic [7:0] exp_rx[$];
	int num_errors = 0, comparisons = 0, seed, k;
	always #4 mclk = ~mclk;
	ubu_uart u_ubu_uart (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_data(out_data), .out_valid(out_valid),
		.out_pkt_end(out_pkt_end), .out_crc_ok(out_crc_ok), .out_ready(out_ready), .hi_speed(hs),
		.in_req(in_req), .in_ack(in_ack), .in_nak(in_nak), .in_len(in_len), .in_pop(in_pop), .in_data(in_data),
		.txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n));
	ubu_remote #(.BIT(BIT)) u_remote (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n),
		.hold(hold), .nb(nb), .got_stb(got_stb), .got(got));
	task automatic fail(input string m);
		num_errors++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask : fail
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd <= 1;
		reg_addr <= a;
		exp_rd.push_back(e);
		@(posedge mclk);
		reg_rd <= 0;
	endtask : rd
	task automatic pkt(input int n, input logic ok);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge mclk);
			out_valid <= 1;
			out_data <= pb[i];
			out_pkt_end <= (i == n - 1);
			out_crc_ok <= ok && (i == n - 1);
			while (out_ready !== 1'b1)
				@(posedge mclk);
		end
		@(posedge mclk);
		out_valid <= 0;
		out_pkt_end <= 0;
		out_crc_ok <= 0;
	endtask : pkt
	task automatic bin(input logic ack, input int n);
		int i;
		@(posedge mclk);
		in_req <= 1;
		@(posedge mclk);
		in_req <= 0;
		#1;
		comparisons++;
		if (in_ack !== ack || in_nak !== !ack || (ack && in_len !== 11'(n))) fail("bulk-in answer");
		for (i = 0; i < n; i++)
		begin
			@(posedge mclk);
			in_pop <= 1;
		end
		@(posedge mclk);
		in_pop <= 0;
	endtask : bin
	function automatic int nbits(input logic [6:0] f);
		return (f[1:0] == BITS_7) ? 7 : (f[1:0] == BITS_8) ? 8 : 9;
	endfunction : nbits
	function automatic logic [9:0] frame(input logic [6:0] f, input logic [8:0] v);
		logic [9:0] r;
		r = 10'(v) & ((10'h1 << nbits(f)) - 10'h1);
		if (f[CFG_PAR_EN])
			r[nbits(f)] = ^r ^ f[CFG_PAR_ODD];
		return r;
	endfunction : frame
	always @(posedge mclk)
		rd_d <= reg_rd;
	always @(negedge mclk)
	begin
		if (rd_d === 1'b1)
		begin
			comparisons++;
			if (exp_rd.size() == 0 || reg_rdata !== exp_rd.pop_front()) fail("register read");
		end
		if (in_pop === 1'b1)
		begin
			comparisons++;
			if (exp_rx.size() == 0 || in_data !== exp_rx.pop_front()) fail("received byte");
		end
	end
	always @(posedge got_stb)
	begin
		comparisons++;
		if (exp_tx.size() == 0 || got !== exp_tx.pop_front()) fail("sent character");
	end
	initial
	begin
		seed = 32'h8b84f31a;
		repeat (20) @(posedge mclk);
		sys_rst <= 0;
		rd(ADDR_LINE_CFG, 32'h01);
		rd(ADDR_FLOW_CTRL, 32'h0);
		rd(ADDR_BAUD_DIV, 32'(BAUD_DIV_RST));
		rd(4'hF, 32'h0);
		$display("test defaults finished");
		wr(ADDR_BAUD_DIV, 32'h2);
		for (k = 0; k < 3; k++)
			pb[k] = 8'($random(seed));
		pkt(3, 0);
		for (k = 0; k < 3; k++)
			exp_tx.push_back(frame(7'h01, 9'(pb[k])));
		pkt(3, 1);
		d = 9'($random(seed));
		u_remote.send(frame(7'h01, d));
		exp_rx.push_back(d[7:0]);
		bin(0, 0);
		repeat (50 * BIT) @(posedge mclk);
		bin(1, 1);
		$display("test bulk transfers finished");
		wr(ADDR_LINE_RATE, 32'd9600);
		rd(ADDR_RX_CTRL, 32'h1);
		hs <= 1;
		for (k = 0; k < 5; k++)
		begin
			c = fmt[k];
			wr(ADDR_LINE_CFG, 32'(c));
			nb <= 4'(nbits(c) + int'(c[CFG_PAR_EN]));
			pb[0] = 8'($random(seed));
			pb[1] = 8'($random(seed));
			if (c[CFG_TX_WIDE])
				exp_tx.push_back(frame(c, {pb[1][0], pb[0]}));
			else
			begin
				exp_tx.push_back(frame(c, {1'b0, pb[0]}));
				exp_tx.push_back(frame(c, {1'b0, pb[1]}));
			end
			pkt(2, 1);
			repeat (30 * BIT) @(posedge mclk);
			d = 9'($random(seed));
			u_remote.send(frame(c, d));
			exp_rx.push_back(nbits(c) == 7 ? {1'b0, d[6:0]} : d[7:0]);
			if (c[CFG_RX_WIDE])
				exp_rx.push_back(nbits(c) == 9 ? {7'h0, d[8]} : 8'h00);
			repeat (2 * BIT) @(posedge mclk);
			bin(1, c[CFG_RX_WIDE] ? 2 : 1);
			$display("test format %0d finished", k);
		end
		rd(ADDR_ERR_STATUS, 32'h0);
		wr(ADDR_LINE_CFG, 32'h01);
		nb <= 8;
		wr(ADDR_FLOW_CTRL, 32'(FLOW_SW));
		u_remote.send(10'(XOFF_RST));
		pb[0] = 8'($random(seed));
		pkt(1, 1);
		repeat (40 * BIT) @(posedge mclk);
		exp_tx.push_back(10'(pb[0]));
		u_remote.send(10'(XON_RST));
		repeat (40 * BIT) @(posedge mclk);
		hold <= 1;
		wr(ADDR_FLOW_CTRL, 32'(FLOW_HW));
		wr(ADDR_PIN_MODE, 32'(PIN_RTS));
		repeat (4) @(posedge mclk);
		comparisons++;
		if (rts_n !== 1'b0) fail("rts not asserted");
		pkt(1, 1);
		repeat (40 * BIT) @(posedge mclk);
		exp_tx.push_back(10'(pb[0]));
		hold <= 0;
		repeat (40 * BIT) @(posedge mclk);
		wr(ADDR_PIN_MODE, 32'(PIN_DTR));
		repeat (4) @(posedge mclk);
		comparisons++;
		if (dtr_n !== 1'b0 || rts_n !== 1'b1 || exp_tx.size() != 0) fail("handshake pins");
		$display("test flow control finished");
		conclude();
	end
	initial
	begin
		repeat (90000) @(posedge mclk);
		fail("watchdog");
		conclude();
	end
endmodule : tb
bind ubu_uart ubu_checker u_ubu_checker (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hi_speed(hi_speed),
	.in_req(in_req), .in_ack(in_ack), .in_nak(in_nak), .in_len(in_len), .txd(txd), .rts_n(rts_n),
	.dtr_n(dtr_n));
`default_nettype wire
